// *** dv/bsld_core_asserts.sv ***
// Port-level checks of the bus and I/O address of the slice
`timescale 1ns/1ps
module bsld_core_asserts
  import bsld_pkg::*;
(
  input wire logic        clk,      // Core clock
  input wire logic        rst,      // Async reset, high
  input wire logic        wb_cyc_i, // Bus cycle
  input wire logic        wb_stb_i, // Bus strobe
  input wire logic        wb_we_i,  // Bus write
  input wire logic [7:0]  wb_adr_i, // Byte address
  input wire logic [3:0]  wb_sel_i, // Byte lanes
  input wire logic [31:0] wb_dat_i, // Write data
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic        wb_ack_o, // Acknowledge
  input wire logic [4:0]  io_addr,  // I/O address
  input wire logic [7:0]  io_rdata  // I/O contents
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire rd_ack = wb_ack_o & ~wb_we_i;
  wire unmap  = ~wb_adr_i[7] & (wb_adr_i > ADR_STAT);

  // ==========================================================
  // Bus answers
  a_ack_next_cycle: assert property (
    $rose(wb_cyc_i & wb_stb_i) |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  a_ack_one_pulse: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_needs_req: assert property (
    wb_ack_o |-> wb_cyc_i && wb_stb_i && $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a standing request");

  // ==========================================================
  // I/O address follows the launched opcode
  a_io_addr_cause: assert property (
    $changed(io_addr) |->
      $past(wb_ack_o && wb_we_i && wb_adr_i == ADR_INSTR))
    else $error("io address moved without an opcode write");
  a_io_addr_bits: assert property (
    $changed(io_addr) |-> io_addr == $past(wb_dat_i[7:3]))
    else $error("io address not taken from opcode bits");

  // ==========================================================
  // Read data widths
  a_stat_layout: assert property (
    rd_ack && wb_adr_i == ADR_STAT |->
      wb_dat_o[31:6] == 26'h0 && wb_dat_o[3:2] == 2'h0)
    else $error("status word has stray bits");
  a_flags_byte: assert property (
    rd_ack && wb_adr_i == ADR_FLAGS |-> wb_dat_o[31:8] == 24'h0)
    else $error("flags wider than a byte");
  a_pc_word: assert property (
    rd_ack && wb_adr_i == ADR_PC |-> wb_dat_o[31:16] == 16'h0)
    else $error("program counter wider than a word");
  a_gpr_byte: assert property (
    rd_ack && wb_adr_i[7] |-> wb_dat_o[31:8] == 24'h0)
    else $error("working register wider than a byte");
  a_unmapped_zero: assert property (
    rd_ack && unmap |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
endmodule : bsld_core_asserts

bind bsld_core bsld_core_asserts bsld_core_asserts_inst (
  .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .io_addr(io_addr), .io_rdata(io_rdata));

// *** dv/bsld_io_model.sv ***
// I/O register space answering the core's I/O address
`timescale 1ns/1ps
module bsld_io_model
(
  input  wire logic       clk,      // Core clock
  input  wire logic       set_en,   // Load one I/O register
  input  wire logic [4:0] set_addr, // Register to load
  input  wire logic [7:0] set_data, // New contents
  input  wire logic [4:0] io_addr,  // Address from the core
  output logic      [7:0] io_rdata  // Contents of that register
);
  logic [7:0] io_regs [32];

  initial
    for (int i = 0; i < 32; i++) io_regs[i] = 8'h00;

  always @(posedge clk)
    if (set_en) io_regs[set_addr] <= set_data;

  // Combinational so the bit is ready within the execute cycle
  assign io_rdata = io_regs[io_addr];
endmodule : bsld_io_model

// *** dv/tb.sv ***
// Self-checking bench for the branch/skip/load slice
`timescale 1ns/1ps
module tb
  import bsld_pkg::*;
;
  typedef struct packed {
    logic [15:0] op;
    logic [15:0] nx;
    logic [7:0]  fl;
    logic [7:0]  fx;
    logic [15:0] pc;
    logic [5:0]  st;
  } bsld_row_t;

  logic        clk      = 1'b0;
  logic        rst      = 1'b1;
  logic        wb_cyc   = 1'b0;
  logic        wb_stb   = 1'b0;
  logic        wb_we    = 1'b0;
  logic [7:0]  wb_adr   = 8'h00;
  logic [3:0]  wb_sel   = 4'h0;
  logic [31:0] wb_wdat  = 32'h0;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  logic [4:0]  io_addr;
  logic [7:0]  io_rdata;
  logic        set_en   = 1'b0;
  logic [4:0]  set_addr = 5'h00;
  logic [7:0]  set_data = 8'h00;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          cyc_cnt   = 0;
  logic [31:0] rd;
  bsld_row_t   rows [$];
  bsld_row_t   r;
  logic [7:0]  f;

  always #20 clk = ~clk;

  bsld_core bsld_core_inst (
    .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .io_addr(io_addr), .io_rdata(io_rdata));
  bsld_io_model bsld_io_model_inst (
    .clk(clk), .set_en(set_en), .set_addr(set_addr),
    .set_data(set_data), .io_addr(io_addr), .io_rdata(io_rdata));

  // ==========================================================
  // Tasks
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  // Request stands until ack is sampled; no fixed latency assumed
  task automatic bus(input logic we, input logic [7:0] adr,
                     input logic [31:0] dat);
    @(posedge clk);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= adr;
    wb_sel  <= 4'hF;
    wb_wdat <= dat;
    do
      @(posedge clk);
    while (wb_ack !== 1'b1);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : bus

  task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
    bus(1'b0, adr, 32'h0);
    check(rd, exp);
  endtask : rdchk

  // Leaves the final status word in rd
  task automatic exec(input logic [15:0] o, input logic [15:0] n);
    bus(1'b1, ADR_NEXT, {16'h0, n});
    bus(1'b1, ADR_INSTR, {16'h0, o});
    do
      bus(1'b0, ADR_STAT, 32'h0);
    while (rd[ST_BUSY] !== 1'b0);
  endtask : exec

  function automatic logic [7:0] ga(input logic [4:0] n);
    return {1'b1, n, 2'b00};
  endfunction : ga

  always @(posedge clk)
  begin
    cyc_cnt++;
    if (cyc_cnt == 30000)
    begin
      error_cnt++;
      give_verdict();
    end
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    for (int s = 0; s < 8; s++)
      for (int c = 0; c < 2; c++)
        for (int v = 0; v < 2; v++)
        begin
          f = v[0] ? 8'h01 << s : ~(8'h01 << s);
          // Keep S equal to N xor V so signed branches are meaningful
          if (s == FL_S) f[FL_N] = f[FL_S] ^ f[FL_V];
          else f[FL_S] = f[FL_N] ^ f[FL_V];
          r.op = {5'h1E, c[0], v[0] ? 7'h7D : 7'h05, s[2:0]};
          r.nx = 16'h0000;
          r.fl = f;
          r.fx = f;
          r.pc = (v[0] ^ c[0]) ? (v[0] ? 16'h000E : 16'h0016) : 16'h0011;
          r.st = (v[0] ^ c[0]) ? 6'h20 : 6'h10;
          rows.push_back(r);
        end
    rows.push_back('{16'hFC55, 16'h0000, 8'hA5, 8'hA5, 16'h0011, 6'h10});
    rows.push_back('{16'hFE55, 16'h0000, 8'hA5, 8'hA5, 16'h0012, 6'h20});
    rows.push_back('{16'hFE55, 16'h9000, 8'hA5, 8'hA5, 16'h0013, 6'h30});
    rows.push_back('{16'hFC54, 16'h940C, 8'hA5, 8'hA5, 16'h0013, 6'h30});
    rows.push_back('{16'h991A, 16'h0000, 8'h5A, 8'h5A, 16'h0011, 6'h10});
    rows.push_back('{16'h9B1A, 16'h920C, 8'h5A, 8'h5A, 16'h0012, 6'h20});
    rows.push_back('{16'h9919, 16'h940E, 8'h5A, 8'h5A, 16'h0013, 6'h30});
    rows.push_back('{16'h9B19, 16'h0000, 8'h5A, 8'h5A, 16'h0011, 6'h10});
    rows.push_back('{16'h3400, 16'h0000, 8'hFF, 8'hC2, 16'h0011, 6'h10});
    rows.push_back('{16'h3401, 16'h0000, 8'h00, 8'h35, 16'h0011, 6'h10});
    rows.push_back('{16'h3C00, 16'h0000, 8'h00, 8'h0D, 16'h0011, 6'h10});
    rows.push_back('{16'h0000, 16'h0000, 8'h00, 8'h00, 16'h0011, 6'h12});
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rdchk(ADR_PC, {16'h0, PC_RST});
    rdchk(ADR_FLAGS, {24'h0, FLAGS_RST});
    rdchk(ADR_STAT, 32'h0);
    rdchk(ga(5'h1F), 32'h0);
    @(posedge clk);
    set_en   <= 1'b1;
    set_addr <= 5'h03;
    set_data <= 8'h04;
    @(posedge clk);
    set_en <= 1'b0;
    bus(1'b1, ga(5'h05), 32'h0000_0020);
    bus(1'b1, ga(5'h10), 32'h0000_0040);
    foreach (rows[i])
    begin
      r = rows[i];
      bus(1'b1, ADR_PC, 32'h0000_0010);
      bus(1'b1, ADR_FLAGS, {24'h0, r.fl});
      exec(r.op, r.nx);
      check({26'h0, rd[5:0]}, {26'h0, r.st});
      rdchk(ADR_PC, {16'h0, r.pc});
      rdchk(ADR_FLAGS, {24'h0, r.fx});
    end
    rdchk(ga(5'h10), 32'h0000_0040);
    // Pointer loads and X stores through data memory
    bus(1'b1, ga(PTR_X), 32'h0000_0030);
    bus(1'b1, ga(PTR_X + 5'h01), 32'h0);
    bus(1'b1, ga(5'h01), 32'h0000_00A5);
    bus(1'b1, ga(5'h02), 32'h0000_005A);
    exec(16'h921D, 16'h0000);
    check({26'h0, rd[5:0]}, 32'h0000_0020);
    rdchk(ga(PTR_X), 32'h0000_0031);
    exec(16'h922C, 16'h0000);
    rdchk(ga(PTR_X), 32'h0000_0031);
    exec(16'h903E, 16'h0000);
    check({26'h0, rd[5:0]}, 32'h0000_0020);
    rdchk(ga(PTR_X), 32'h0000_0030);
    rdchk(ga(5'h03), 32'h0000_00A5);
    exec(16'h904D, 16'h0000);
    rdchk(ga(5'h04), 32'h0000_00A5);
    rdchk(ga(PTR_X), 32'h0000_0031);
    bus(1'b1, ga(PTR_Y), 32'h0000_0030);
    bus(1'b1, ga(PTR_Y + 5'h01), 32'h0);
    exec(16'h8059, 16'h0000);
    rdchk(ga(5'h05), 32'h0000_005A);
    rdchk(ga(PTR_Y), 32'h0000_0030);
    bus(1'b1, ga(PTR_Z), 32'h0000_0030);
    bus(1'b1, ga(PTR_Z + 5'h01), 32'h0);
    exec(16'h9071, 16'h0000);
    rdchk(ga(5'h07), 32'h0000_00A5);
    rdchk(ga(PTR_Z), 32'h0000_0031);
    bus(1'b1, ADR_PC, 32'h0000_0010);
    bus(1'b1, ADR_FLAGS, 32'h0000_003C);
    exec(16'h9060, 16'h0031);
    check({26'h0, rd[5:0]}, 32'h0000_0020);
    rdchk(ga(5'h06), 32'h0000_005A);
    rdchk(ADR_PC, 32'h0000_0012);
    rdchk(ADR_FLAGS, 32'h0000_003C);
    // Unmapped place and read-only status
    bus(1'b1, 8'h40, 32'hFFFF_FFFF);
    rdchk(8'h40, 32'h0);
    bus(1'b0, ADR_STAT, 32'h0);
    f = rd[7:0];
    bus(1'b1, ADR_STAT, 32'hFFFF_FFFF);
    rdchk(ADR_STAT, {24'h0, f});
    give_verdict();
  end
endmodule : tb

// *** src/bsld_core.sv ***
// Execute slice: compare, skips, flag branches, loads, X stores
// What this block does
// RQ1: compare_immediate subtracts constant, sets Z N V C H, one clock
// RQ2: skip_reg_bit_clear skips next when register bit is zero
// RQ3: skip_reg_bit_set skips next when register bit is one
// RQ4: skip_port_bit_clear skips next when I/O bit reads zero
// RQ5: skip_port_bit_set skips next when I/O bit reads one
// RQ6: branch_flag_set/clear test flag s, jump to PC+k+1
// RQ7: branch_equal on Z one, branch_not_equal on Z zero
// RQ8: carry branches taken on C; lower/same_higher are same encodings
// RQ9: branch_minus on N one, branch_plus on N zero
// RQ10: signed branches test N xor V
// RQ11: half-carry branches test H with same target
// RQ12: T-bit branches test T, 1 clock untaken, 2 taken
// RQ13: branch_overflow_set taken on V one, flags untouched
// RQ14: interrupt branches test global interrupt flag I
// RQ15: post-increment load reads pointer target then adds one
// RQ16: pre-decrement load subtracts one then reads target
// RQ17: displaced load reads Y or Z plus q, pointer kept
// RQ18: load_direct_memory reads address k, flags kept, 2 clocks
// RQ19: X store writes source to (X), post-increment form bumps X
// RQ20: skip costs 1, 2 or 3 clocks by skipped length
// RQ21: offset k is signed, added to PC+1 only when taken
`timescale 1ns/1ps
module bsld_core
  import bsld_pkg::*;
(
  input  wire logic        clk,      // Core clock, 25 MHz
  input  wire logic        rst,      // Async reset, high
  input  wire logic        wb_cyc_i, // Bus cycle
  input  wire logic        wb_stb_i, // Bus strobe
  input  wire logic        wb_we_i,  // Bus write
  input  wire logic [7:0]  wb_adr_i, // Byte address
  input  wire logic [3:0]  wb_sel_i, // Byte lanes
  input  wire logic [31:0] wb_dat_i, // Write data
  output logic      [31:0] wb_dat_o, // Read data
  output logic             wb_ack_o, // Acknowledge
  output logic      [4:0]  io_addr,  // I/O register address
  input  wire logic [7:0]  io_rdata  // I/O register contents
);

  // ==========================================================
  // Helpers
  function automatic logic [31:0] be_merge(input logic [31:0] o,
                                           input logic [31:0] n,
                                           input logic [3:0]  s);
    logic [31:0] m;
    m = o;
    for (int i = 0; i < 4; i++)
    begin
      if (s[i])
      begin
        m[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return m;
  endfunction : be_merge

  function automatic logic two_word(input logic [15:0] op);
    return (op[15:9] == OP_LDG && op[3:0] == LO_DIR) ||
           (op[15:9] == OP_STG && op[3:0] == LO_DIR) ||
           (op[15:9] == OP_JCG && op[3:2] == 2'b11);
  endfunction : two_word

  // ==========================================================
  // State
  bsld_state_t state_r;
  bsld_state_t state_nxt;
  logic [15:0] instr_r;
  logic [15:0] next_r;
  logic [15:0] pc_r;
  logic [15:0] pc_nxt;
  logic [7:0]  flags_r;
  logic [7:0]  flags_nxt;
  logic [1:0]  wait_r;
  logic [1:0]  wait_nxt;
  logic [1:0]  last_cyc_r;
  logic        ill_r;
  logic        ill_nxt;
  logic [4:0]  ld_dst_r;
  logic [7:0]  gpr_r [0:31];
  logic        ack_r;
  logic [31:0] rdat_r;
  logic [4:0]  io_addr_r;
  logic [1:0]  extra;
  logic        ptr_we;
  logic        mem_we;

  // ==========================================================
  // Bus decode
  wire         bus_req  = wb_cyc_i & wb_stb_i;
  wire         wr_fire  = bus_req & wb_we_i & ack_r;
  wire         idle     = (state_r == S_IDLE);
  wire         gpr_hit  = wb_adr_i[GPR_BIT];
  wire         wr_idle  = wr_fire & idle;
  wire         launch   = wr_idle & (wb_adr_i == ADR_INSTR);
  wire         next_wr  = wr_idle & (wb_adr_i == ADR_NEXT);
  wire         pc_wr    = wr_idle & (wb_adr_i == ADR_PC);
  wire         flags_wr = wr_idle & (wb_adr_i == ADR_FLAGS);
  wire         gpr_wr   = wr_idle & gpr_hit;
  wire [31:0]  instr_wv = be_merge({16'h0000, instr_r}, wb_dat_i,
                                   wb_sel_i);
  wire [31:0]  next_wv  = be_merge({16'h0000, next_r}, wb_dat_i,
                                   wb_sel_i);
  wire [31:0]  pc_wv    = be_merge({16'h0000, pc_r}, wb_dat_i,
                                   wb_sel_i);
  wire [31:0]  flags_wv = be_merge({24'h000000, flags_r}, wb_dat_i,
                                   wb_sel_i);
  wire [31:0]  gpr_wv   = be_merge({24'h000000, gpr_r[wb_adr_i[6:2]]},
                                   wb_dat_i, wb_sel_i);
  wire [31:0]  stat_v   = {26'h0000000, last_cyc_r, 2'b00, ill_r,
                           ~idle};
  wire [31:0]  rd_val   =
    gpr_hit                  ? {24'h000000, gpr_r[wb_adr_i[6:2]]} :
    (wb_adr_i == ADR_INSTR)  ? {16'h0000, instr_r} :
    (wb_adr_i == ADR_NEXT)   ? {16'h0000, next_r} :
    (wb_adr_i == ADR_PC)     ? {16'h0000, pc_r} :
    (wb_adr_i == ADR_FLAGS)  ? {24'h000000, flags_r} :
    (wb_adr_i == ADR_STAT)   ? stat_v : 32'h00000000;

  // ==========================================================
  // Compare with immediate
  wire [7:0]   cmp_k   = {instr_r[11:8], instr_r[3:0]};
  wire [7:0]   cmp_rd  = gpr_r[{1'b1, instr_r[7:4]}];
  wire [8:0]   cmp_d9  = {1'b0, cmp_rd} - {1'b0, cmp_k};
  wire [7:0]   cmp_r   = cmp_d9[7:0];
  wire         cmp_h   = (~cmp_rd[3] & cmp_k[3]) | (cmp_k[3] & cmp_r[3])
                       | (cmp_r[3] & ~cmp_rd[3]);
  wire         cmp_v   = (cmp_rd[7] & ~cmp_k[7] & ~cmp_r[7])
                       | (~cmp_rd[7] & cmp_k[7] & cmp_r[7]);
  wire [7:0]   flags_cmp = {flags_r[FL_I], flags_r[FL_T], cmp_h,
                            cmp_r[7] ^ cmp_v, cmp_v, cmp_r[7],
                            cmp_r == 8'h00, cmp_d9[8]}; // RQ1
  wire         is_cmp  = (instr_r[15:12] == OP_CMPI);

  // ==========================================================
  // Skips
  wire         is_skr  = (instr_r[15:10] == OP_SKR) & ~instr_r[3];
  wire         is_skp  = (instr_r[15:8] == OP_SKPC) |
                         (instr_r[15:8] == OP_SKPS);
  wire         reg_bit = gpr_r[instr_r[8:4]][instr_r[2:0]];
  wire         io_bit  = io_rdata[instr_r[2:0]];
  // Bit 9 selects the set form for both register and port skips
  wire         skr_hit = is_skr & (reg_bit == instr_r[9]); // RQ2 RQ3
  wire         skp_hit = is_skp & (io_bit == instr_r[9]);  // RQ4 RQ5
  wire [1:0]   skip_len = two_word(next_r) ? EXTRA_TWO
                                           : EXTRA_ONE; // RQ20

  // ==========================================================
  // Flag branches: every named branch is this encoding
  wire         is_brf  = (instr_r[15:11] == OP_BRF);
  wire         br_flag = flags_r[instr_r[2:0]];
  // Bit 10 picks the clear form; flag s covers Z C N V S H T I
  wire         br_take = is_brf & (br_flag ^ instr_r[10]);
  // RQ7 RQ8 RQ9 RQ10 RQ11 RQ12 RQ13 RQ14
  wire [15:0]  br_off  = {{9{instr_r[9]}}, instr_r[9:3]}; // RQ21
  wire [15:0]  br_tgt  = pc_r + 16'h0001 + br_off;        // RQ6

  // ==========================================================
  // Loads and X stores
  wire [3:0]   lo      = instr_r[3:0];
  wire         grp_ld  = (instr_r[15:9] == OP_LDG);
  wire         is_ldi  = grp_ld & (lo == LO_ZINC || lo == LO_ZDEC ||
                         lo == LO_YINC || lo == LO_YDEC || lo == LO_X ||
                         lo == LO_XINC || lo == LO_XDEC);
  wire         is_lds  = grp_ld & (lo == LO_DIR);
  wire         is_ldd  = (instr_r[15:14] == OP_DISP) & ~instr_r[12] &
                         ~instr_r[9];
  wire         is_stx  = (instr_r[15:9] == OP_STG) &
                         (lo == LO_X || lo == LO_XINC);
  wire         is_load = is_ldi | is_lds | is_ldd;
  wire         grp_ind = is_ldi | is_stx;
  wire         p_inc   = grp_ind & (lo[1:0] == MD_INC);
  wire         p_dec   = grp_ind & (lo[1:0] == MD_DEC);
  wire [5:0]   disp_q  = is_ldd ? {instr_r[13], instr_r[11:10],
                                   instr_r[2:0]} : 6'h00;
  wire [4:0]   ptr_lo  = is_ldd          ? (lo[3] ? PTR_Y : PTR_Z) :
                         (lo[3:2] == 2'b11) ? PTR_X :
                         lo[3]           ? PTR_Y : PTR_Z;
  wire [4:0]   ptr_hi  = {ptr_lo[4:1], 1'b1};
  wire [15:0]  ptr_val = {gpr_r[ptr_hi], gpr_r[ptr_lo]};
  wire [15:0]  ptr_new = p_dec ? ptr_val - 16'h0001
                               : ptr_val + 16'h0001;
  // Pre-decrement addresses the already lowered pointer
  wire [15:0]  eff_adr = is_lds ? next_r :                // RQ18
                         p_dec  ? ptr_new :               // RQ16
                         ptr_val + {10'h000, disp_q};     // RQ15 RQ17
  wire [7:0]   mem_rd;
  wire         in_exec = (state_r == S_EXEC);

  // ==========================================================
  // Sequencer
  always_comb
  begin
    state_nxt = state_r;
    pc_nxt    = pc_r;
    flags_nxt = flags_r;
    wait_nxt  = wait_r;
    ill_nxt   = ill_r;
    extra     = EXTRA_NO;
    ptr_we    = 1'b0;
    mem_we    = 1'b0;
    case (state_r)
      S_IDLE:
      begin
        if (launch)
        begin
          state_nxt = S_EXEC;
        end
      end
      S_EXEC:
      begin
        state_nxt = S_IDLE;
        pc_nxt    = pc_r + 16'h0001;
        ill_nxt   = 1'b0;
        if (is_cmp)
        begin
          flags_nxt = flags_cmp; // RQ1
        end
        else if (is_skr | is_skp)
        begin
          if (skr_hit | skp_hit)
          begin
            extra  = skip_len;                         // RQ20
            pc_nxt = pc_r + 16'h0001 + {14'h0000, skip_len};
          end
        end
        else if (is_brf)
        begin
          if (br_take)
          begin
            extra  = EXTRA_ONE; // RQ6
            pc_nxt = br_tgt;    // RQ21
          end
        end
        else if (is_load)
        begin
          extra  = EXTRA_ONE;
          ptr_we = p_inc | p_dec; // RQ15 RQ16
          if (two_word(instr_r))
          begin
            pc_nxt = pc_r + 16'h0002; // RQ18
          end
        end
        else if (is_stx)
        begin
          extra  = EXTRA_ONE;
          mem_we = 1'b1;  // RQ19
          ptr_we = p_inc; // RQ19
        end
        else
        begin
          ill_nxt = 1'b1;
        end
        if (extra != EXTRA_NO)
        begin
          state_nxt = is_load ? S_MEM : S_WAIT;
          wait_nxt  = extra - EXTRA_ONE;
        end
      end
      S_MEM:
      begin
        state_nxt = S_IDLE;
      end
      S_WAIT:
      begin
        if (wait_r == EXTRA_NO)
        begin
          state_nxt = S_IDLE;
        end
        else
        begin
          wait_nxt = wait_r - EXTRA_ONE;
        end
      end
      default:
      begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_r    <= S_IDLE;
      instr_r    <= WORD_RST;
      next_r     <= WORD_RST;
      pc_r       <= PC_RST;
      flags_r    <= FLAGS_RST;
      wait_r     <= EXTRA_NO;
      last_cyc_r <= EXTRA_NO;
      ill_r      <= 1'b0;
      ld_dst_r   <= 5'h00;
      io_addr_r  <= 5'h00;
    end
    else
    begin
      state_r  <= state_nxt;
      wait_r   <= wait_nxt;
      ill_r    <= ill_nxt;
      instr_r  <= launch ? instr_wv[15:0] : instr_r;
      next_r   <= next_wr ? next_wv[15:0] : next_r;
      pc_r     <= pc_wr ? pc_wv[15:0] : pc_nxt;
      flags_r  <= flags_wr ? flags_wv[7:0] : flags_nxt;
      // Port address is loaded at launch with the opcode, ready for the skip test in the execute cycle
      io_addr_r <= launch ? instr_wv[7:3] : io_addr_r;
      if (in_exec)
      begin
        last_cyc_r <= CYC_BASE + extra;
        ld_dst_r   <= instr_r[8:4];
      end
    end
  end

  // ==========================================================
  // Working registers
  // A load whose target is its own pointer keeps the loaded byte
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < 32; i++)
      begin
        gpr_r[i] <= 8'h00;
      end
    end
    else
    begin
      if (gpr_wr)
      begin
        gpr_r[wb_adr_i[6:2]] <= gpr_wv[7:0];
      end
      if (in_exec && ptr_we)
      begin
        gpr_r[ptr_lo] <= ptr_new[7:0];  // RQ15 RQ16 RQ19
        gpr_r[ptr_hi] <= ptr_new[15:8];
      end
      if (state_r == S_MEM)
      begin
        gpr_r[ld_dst_r] <= mem_rd; // RQ15 RQ16 RQ17 RQ18
      end
    end
  end

  bsld_dmem u_dmem (
    .clk   (clk),
    .rst   (rst),
    .we    (in_exec & mem_we),
    .addr  (eff_adr[DMEM_AW-1:0]),
    .wdata (gpr_r[instr_r[8:4]]),
    .rdata (mem_rd)
  );

  // ==========================================================
  // Bus slave
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h00000000;
    end
    else
    begin
      ack_r <= bus_req & ~ack_r;
      if (bus_req & ~ack_r)
      begin
        rdat_r <= rd_val;
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign io_addr  = io_addr_r;

endmodule : bsld_core

// *** src/bsld_dmem.sv ***
// Byte-wide data memory with registered read data
`timescale 1ns/1ps
module bsld_dmem
  import bsld_pkg::*;
(
  input  wire logic               clk,   // Core clock
  input  wire logic               rst,   // Async reset, high
  input  wire logic               we,    // Write strobe
  input  wire logic [DMEM_AW-1:0] addr,  // Byte address
  input  wire logic [7:0]         wdata, // Write byte
  output logic      [7:0]         rdata  // Read byte, one clock late
);

  logic [7:0] mem_r [0:(1<<DMEM_AW)-1];

  // ==========================================================
  // Storage
  // Array has no reset so it maps onto plain RAM
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem_r[addr] <= wdata;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdata <= 8'h00;
    end
    else
    begin
      rdata <= mem_r[addr];
    end
  end

endmodule : bsld_dmem

// *** src/bsld_pkg.sv ***
// Constants, register map and state type for the branch/skip/load slice
package bsld_pkg;

  // ==========================================================
  // Register map (byte addresses on the bus)
  localparam logic [7:0] ADR_INSTR = 8'h00;
  localparam logic [7:0] ADR_NEXT  = 8'h04;
  localparam logic [7:0] ADR_PC    = 8'h08;
  localparam logic [7:0] ADR_FLAGS = 8'h0C;
  localparam logic [7:0] ADR_STAT  = 8'h10;
  localparam int         GPR_BIT   = 7;

  // ==========================================================
  // Reset values
  localparam logic [15:0] PC_RST    = 16'h0000;
  localparam logic [7:0]  FLAGS_RST = 8'h00;
  localparam logic [15:0] WORD_RST  = 16'h0000;

  // ==========================================================
  // Status flag positions
  localparam int FL_C = 0;
  localparam int FL_Z = 1;
  localparam int FL_N = 2;
  localparam int FL_V = 3;
  localparam int FL_S = 4;
  localparam int FL_H = 5;
  localparam int FL_T = 6;
  localparam int FL_I = 7;

  // ==========================================================
  // Status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_ILL  = 1;
  localparam int ST_CYC  = 4;

  // ==========================================================
  // Pointer pairs (low byte index)
  localparam logic [4:0] PTR_X = 5'h1A;
  localparam logic [4:0] PTR_Y = 5'h1C;
  localparam logic [4:0] PTR_Z = 5'h1E;

  // ==========================================================
  // Opcode patterns
  localparam logic [3:0] OP_CMPI  = 4'h3;
  localparam logic [5:0] OP_SKR   = 6'h3F;
  localparam logic [7:0] OP_SKPC  = 8'h99;
  localparam logic [7:0] OP_SKPS  = 8'h9B;
  localparam logic [4:0] OP_BRF   = 5'h1E;
  localparam logic [6:0] OP_LDG   = 7'h48;
  localparam logic [6:0] OP_STG   = 7'h49;
  localparam logic [6:0] OP_JCG   = 7'h4A;
  localparam logic [1:0] OP_DISP  = 2'h2;
  localparam logic [3:0] LO_DIR   = 4'h0;
  localparam logic [3:0] LO_ZINC  = 4'h1;
  localparam logic [3:0] LO_ZDEC  = 4'h2;
  localparam logic [3:0] LO_YINC  = 4'h9;
  localparam logic [3:0] LO_YDEC  = 4'hA;
  localparam logic [3:0] LO_X     = 4'hC;
  localparam logic [3:0] LO_XINC  = 4'hD;
  localparam logic [3:0] LO_XDEC  = 4'hE;
  localparam logic [1:0] MD_INC   = 2'h1;
  localparam logic [1:0] MD_DEC   = 2'h2;

  // ==========================================================
  // Timing counts in clocks
  localparam logic [1:0] CYC_BASE  = 2'h1;
  localparam logic [1:0] EXTRA_NO  = 2'h0;
  localparam logic [1:0] EXTRA_ONE = 2'h1;
  localparam logic [1:0] EXTRA_TWO = 2'h2;

  // ==========================================================
  // Data memory
  localparam int DMEM_AW = 8;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_EXEC = 2'b01,
    S_MEM  = 2'b10,
    S_WAIT = 2'b11
  } bsld_state_t;

endpackage : bsld_pkg
